// ===== hdl/dbs_pkg.sv
// Constants for the dual buck sequencing and fault controller
package dbs_pkg;
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned CLK_MHZ      = CLK_HZ / 1_000_000;
  // Times and frequencies as specified
  localparam int unsigned START_DLY_US = 240;
  localparam int unsigned SS_TOTAL_US  = 13_000;
  localparam int unsigned PG_DLY_US    = 500;
  localparam int unsigned OV_BLANK_NS  = 1_500;
  localparam int unsigned UV_DLY_US    = 1_000;
  localparam int unsigned UV_BLANK_US  = 8_500;
  localparam int unsigned SKIP_MIN_HZ  = 33_000;
  localparam int unsigned FSW_LOW_HZ   = 300_000;
  localparam int unsigned FSW_MID_HZ   = 400_000;
  localparam int unsigned FSW_HIGH_HZ  = 600_000;
  // Cycle counts derived from the clock rate, then fixed tick and step counts and counter widths
  localparam int unsigned START_CYC = START_DLY_US * CLK_MHZ;
  localparam int unsigned RAMP_CYC  = SS_TOTAL_US * CLK_MHZ - START_CYC;
  localparam int unsigned PG_CYC    = PG_DLY_US * CLK_MHZ;
  localparam int unsigned OV_CYC    = (OV_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned UV_CYC    = UV_DLY_US * CLK_MHZ;
  localparam int unsigned BLANK_CYC = UV_BLANK_US * CLK_MHZ;
  localparam int unsigned SKIP_CYC  = CLK_HZ / SKIP_MIN_HZ;
  localparam int unsigned PER_LOW   = CLK_HZ / FSW_LOW_HZ;
  localparam int unsigned PER_MID   = CLK_HZ / FSW_MID_HZ;
  localparam int unsigned PER_HIGH  = CLK_HZ / FSW_HIGH_HZ;
  localparam int unsigned OC_TICKS  = 16;
  localparam int unsigned PGW_TICKS = 128;
  localparam int unsigned RAMP_STEPS = 256;
  localparam int unsigned CNT_W     = 21;
  localparam int unsigned PER_W     = 12;
  // Register map
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [7:0]  REG_FAULT  = 8'h08;
  localparam logic [1:0]  CTRL_RESET = 2'h3;
  // Frequency select codes
  localparam logic [1:0]  FSEL_LOW  = 2'h0;
  localparam logic [1:0]  FSEL_MID  = 2'h1;
  localparam logic [1:0]  FSEL_HIGH = 2'h2;
  // Synchroniser vector layout: per channel block, then globals
  localparam int unsigned IN_EN = 0, IN_OV = 1, IN_UV = 2, IN_OC = 3, IN_SC = 4;
  localparam int unsigned IN_CMP = 5, IN_LIGHT = 6, IN_PREB = 7, IN_WIN = 8;
  localparam int unsigned CH_IN_W = 9;
  localparam int unsigned G_VINLO = 18, G_BIASLO = 19, G_THERM = 20, G_V2HI = 21;
  localparam int unsigned G_BYPREQ = 22, G_TRANS = 23, G_LDOEN = 24, G_SKIPHI = 25;
  localparam int unsigned G_SKIPLO = 26, G_AUXHI = 27, G_AUXMID = 28, G_FSEL = 29;
  localparam int unsigned IN_W = 31;

  typedef enum logic [5:0] {
    ST_OFF     = 6'b000001,
    ST_DELAY   = 6'b000010,
    ST_RAMP    = 6'b000100,
    ST_READY   = 6'b001000,
    ST_OVLATCH = 6'b010000,
    ST_LATCHED = 6'b100000
  } dbs_state_e;
endpackage : dbs_pkg

// ===== hdl/dbs_sequencer.sv
// Sequencing, switching mode and protection logic for two buck channels
module dbs_sequencer
  import dbs_pkg::*;
#(
  parameter int unsigned START_CYCLES = START_CYC,
  parameter int unsigned RAMP_CYCLES  = RAMP_CYC,
  parameter int unsigned PG_CYCLES    = PG_CYC,
  parameter int unsigned UV_CYCLES    = UV_CYC,
  parameter int unsigned BLANK_CYCLES = BLANK_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [1:0]  channelEnable,
  input  wire logic [1:0]  overvoltageFlag,
  input  wire logic [1:0]  undervoltageFlag,
  input  wire logic [1:0]  overcurrentFlag,
  input  wire logic [1:0]  shortCircuitFlag,
  input  wire logic [1:0]  pwmCompareFlag,
  input  wire logic [1:0]  lightLoadFlag,
  input  wire logic [1:0]  rampAboveFeedback,
  input  wire logic [1:0]  feedbackInWindow,
  input  wire logic        inputSupplyLockout,
  input  wire logic        biasSupplyLockout,
  input  wire logic        thermalShutdownFlag,
  input  wire logic        channel2Above475,
  input  wire logic        fiveVoltRegulatorBypassIn,
  input  wire logic        transientFlag,
  input  wire logic        fiveVoltRegulatorEnablePin,
  input  wire logic        lightLoadModeHigh,
  input  wire logic        lightLoadModeLow,
  input  wire logic        auxRegulatorSelectHigh,
  input  wire logic        auxRegulatorSelectMid,
  input  wire logic [1:0]  frequencySelectCode,
  output logic [1:0]       highGate,
  output logic [1:0]       lowGate,
  output logic [1:0]       dischargeSwitch,
  output logic [15:0]      softStartRef,
  output logic             powerGoodOut,
  output logic             powerGoodOutOe,
  output logic             fiveVoltRegulatorEnable,
  output logic             fiveVoltBypass,
  output logic             auxRegulatorEnable,
  output logic             auxRegulatorSelect12v
);
  localparam int unsigned STEP_CYC = (RAMP_CYCLES / RAMP_STEPS > 0) ?
                                     RAMP_CYCLES / RAMP_STEPS : 1;

  logic [IN_W-1:0] rawIn;
  logic [IN_W-1:0] syncA_q, syncB_q, syncC_q, inF_q;
  logic            lockRst, thermal, boost, forcedMode, skipBoth;
  logic [PER_W-1:0] basePer, perLen, boostCnt_q;
  logic            transPrev_q;
  logic [1:0]      ctrl_q;
  logic [7:0]      wrAddr_q;
  logic            wrPend_q;
  logic [CNT_W-1:0] pgCnt_q;
  logic            pgDelayDone;
  logic [1:0]      chReady, chWinOk, ovLatched;

  dbs_state_e       state_q  [2];
  logic [CNT_W-1:0] seqCnt_q [2];
  logic [7:0]       level_q  [2];
  logic [CNT_W-1:0] blankCnt_q [2];
  logic [CNT_W-1:0] uvCnt_q  [2];
  logic [CNT_W-1:0] ovCnt_q  [2];
  logic [PER_W-1:0] perCnt_q [2];
  logic [PER_W-1:0] skipCnt_q [2];
  logic [4:0]       ocCnt_q  [2];
  logic [7:0]       winCnt_q [2];
  logic [1:0]       ocSeen_q, prebDone_q, lsOv_q, pulse_q, ovLatch_q, uvLatch_q, ocLatch_q;
  logic [1:0]       enPrev_q;

  assign rawIn = {frequencySelectCode, auxRegulatorSelectMid, auxRegulatorSelectHigh,
                  lightLoadModeLow, lightLoadModeHigh, fiveVoltRegulatorEnablePin,
                  transientFlag, fiveVoltRegulatorBypassIn, channel2Above475,
                  thermalShutdownFlag, biasSupplyLockout, inputSupplyLockout,
                  feedbackInWindow[1], rampAboveFeedback[1], lightLoadFlag[1],
                  pwmCompareFlag[1], shortCircuitFlag[1], overcurrentFlag[1],
                  undervoltageFlag[1], overvoltageFlag[1], channelEnable[1],
                  feedbackInWindow[0], rampAboveFeedback[0], lightLoadFlag[0],
                  pwmCompareFlag[0], shortCircuitFlag[0], overcurrentFlag[0],
                  undervoltageFlag[0], overvoltageFlag[0], channelEnable[0]};

  // Three-stage synchroniser, a change counts once stages two and three agree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_q <= '0;
      syncB_q <= '0;
      syncC_q <= '0;
      inF_q   <= '0;
    end else begin
      syncA_q <= rawIn;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
      inF_q   <= (~(syncB_q ^ syncC_q) & syncC_q) | ((syncB_q ^ syncC_q) & inF_q);
    end
  end

  assign lockRst    = inF_q[G_VINLO] | inF_q[G_BIASLO];
  assign thermal    = inF_q[G_THERM];
  assign forcedMode = inF_q[G_SKIPHI];
  assign skipBoth   = inF_q[G_SKIPLO] & ~inF_q[G_SKIPHI];

  // Switching period from the frequency select code
  always_comb begin
    case (inF_q[G_FSEL +: 2])
      FSEL_LOW:  basePer = PER_W'(PER_LOW);
      FSEL_MID:  basePer = PER_W'(PER_MID);
      FSEL_HIGH: basePer = PER_W'(PER_HIGH);
      default:   basePer = PER_W'(PER_LOW);
    endcase
  end

  // Transient boost lasts one normal period at doubled rate
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      boostCnt_q  <= '0;
      transPrev_q <= 1'b0;
    end else begin
      transPrev_q <= inF_q[G_TRANS];
      if (inF_q[G_TRANS] && !transPrev_q) begin
        boostCnt_q <= basePer;
      end else if (boostCnt_q != '0) begin
        boostCnt_q <= boostCnt_q - 1'b1;
      end
    end
  end
  assign boost  = boostCnt_q != '0;
  assign perLen = boost ? (basePer >> 1) : basePer;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic en, ov, uv, oc, sc, cmp, light, preb, win, tick, forced_complementary_switching, ssAct, uvArmed;
      logic hsNext, lsNext, ocTrip, skipNow;
      assign en    = inF_q[ch*CH_IN_W + IN_EN] & ctrl_q[ch];
      assign ov    = inF_q[ch*CH_IN_W + IN_OV];
      assign uv    = inF_q[ch*CH_IN_W + IN_UV];
      assign oc    = inF_q[ch*CH_IN_W + IN_OC];
      assign sc    = inF_q[ch*CH_IN_W + IN_SC];
      assign cmp   = inF_q[ch*CH_IN_W + IN_CMP];
      assign light = inF_q[ch*CH_IN_W + IN_LIGHT];
      assign preb  = inF_q[ch*CH_IN_W + IN_PREB];
      assign win   = inF_q[ch*CH_IN_W + IN_WIN];
      assign tick  = perCnt_q[ch] == '0;
      assign ssAct = (state_q[ch] == ST_DELAY) || (state_q[ch] == ST_RAMP);
      // Channel 2 stays forced when the mode pin floats
      assign forced_complementary_switching  = ssAct || forcedMode || (!skipBoth && ch == 1);
      assign uvArmed = blankCnt_q[ch] == '0;
      assign ocTrip  = sc || (ocCnt_q[ch] == 5'(OC_TICKS));
      assign skipNow = !forced_complementary_switching && light && (skipCnt_q[ch] < PER_W'(SKIP_CYC - 1));

      // Soft-start and fault sequencer
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          state_q[ch]  <= ST_OFF;
          seqCnt_q[ch] <= '0;
          level_q[ch]  <= '0;
          ovLatch_q[ch] <= 1'b0;
          uvLatch_q[ch] <= 1'b0;
          ocLatch_q[ch] <= 1'b0;
        end else if (lockRst || !en || thermal) begin
          state_q[ch]  <= ST_OFF;
          seqCnt_q[ch] <= '0;
          level_q[ch]  <= '0;
          ovLatch_q[ch] <= 1'b0;
          uvLatch_q[ch] <= 1'b0;
          ocLatch_q[ch] <= 1'b0;
        end else begin
          case (state_q[ch])
            ST_OFF: begin
              state_q[ch]  <= ST_DELAY;
              seqCnt_q[ch] <= '0;
            end
            ST_DELAY, ST_RAMP, ST_READY: begin
              if (ocTrip) begin
                state_q[ch]   <= ST_LATCHED;
                ocLatch_q[ch] <= 1'b1;
              end else if (ov && ovCnt_q[ch] == CNT_W'(OV_CYC - 1)) begin
                state_q[ch]   <= ST_OVLATCH;
                ovLatch_q[ch] <= 1'b1;
              end else if (uv && uvArmed && uvCnt_q[ch] == CNT_W'(UV_CYCLES)) begin
                state_q[ch]   <= ST_LATCHED;
                uvLatch_q[ch] <= 1'b1;
              end else if (state_q[ch] == ST_DELAY) begin
                if (seqCnt_q[ch] == CNT_W'(START_CYCLES - 1)) begin
                  state_q[ch]  <= ST_RAMP;
                  seqCnt_q[ch] <= '0;
                end else begin
                  seqCnt_q[ch] <= seqCnt_q[ch] + 1'b1;
                end
              end else if (state_q[ch] == ST_RAMP) begin
                if (seqCnt_q[ch] == CNT_W'(STEP_CYC - 1)) begin
                  seqCnt_q[ch] <= '0;
                  if (level_q[ch] == 8'hff) begin
                    state_q[ch] <= ST_READY;
                  end else begin
                    level_q[ch] <= level_q[ch] + 1'b1;
                  end
                end else begin
                  seqCnt_q[ch] <= seqCnt_q[ch] + 1'b1;
                end
              end
            end
            ST_OVLATCH, ST_LATCHED: begin
              state_q[ch] <= state_q[ch];
            end
            default: state_q[ch] <= ST_OFF;
          endcase
        end
      end

      // Protection timers: OV blanking, UV delay, UV blanking after enable
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          ovCnt_q[ch]    <= '0;
          uvCnt_q[ch]    <= '0;
          blankCnt_q[ch] <= '0;
          enPrev_q[ch]   <= 1'b0;
        end else begin
          enPrev_q[ch] <= en;
          ovCnt_q[ch]  <= ov ? ovCnt_q[ch] + 1'b1 : '0;
          uvCnt_q[ch]  <= (uv && uvArmed) ? uvCnt_q[ch] + 1'b1 : '0;
          if (en && !enPrev_q[ch]) begin
            blankCnt_q[ch] <= CNT_W'(BLANK_CYCLES);
          end else if (!en || lockRst || thermal) begin
            blankCnt_q[ch] <= CNT_W'(BLANK_CYCLES);
          end else if (blankCnt_q[ch] != '0) begin
            blankCnt_q[ch] <= blankCnt_q[ch] - 1'b1;
          end
        end
      end

      // Switching period, skip counter and over-current tick counter
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          perCnt_q[ch]  <= '0;
          skipCnt_q[ch] <= '0;
          pulse_q[ch]   <= 1'b0;
          ocSeen_q[ch]  <= 1'b0;
          ocCnt_q[ch]   <= '0;
        end else if (state_q[ch] == ST_OFF) begin
          perCnt_q[ch]  <= '0;
          skipCnt_q[ch] <= '0;
          pulse_q[ch]   <= 1'b0;
          ocSeen_q[ch]  <= 1'b0;
          ocCnt_q[ch]   <= '0;
        end else begin
          if (tick) begin
            perCnt_q[ch] <= perLen - 1'b1;
            pulse_q[ch]  <= !skipNow && !oc;
            ocSeen_q[ch] <= oc;
            ocCnt_q[ch]  <= ocSeen_q[ch] ? ocCnt_q[ch] + 1'b1 : '0;
          end else begin
            perCnt_q[ch] <= perCnt_q[ch] - 1'b1;
            if (cmp || oc) begin
              pulse_q[ch] <= 1'b0;
            end
            if (oc) begin
              ocSeen_q[ch] <= 1'b1;
            end
          end
          if (tick && !skipNow) begin
            skipCnt_q[ch] <= '0;
          end else if (skipCnt_q[ch] != PER_W'(SKIP_CYC - 1)) begin
            skipCnt_q[ch] <= skipCnt_q[ch] + 1'b1;
          end
        end
      end

      // Pre-bias hold and latched over-voltage low-gate tracking
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          prebDone_q[ch] <= 1'b0;
          lsOv_q[ch]     <= 1'b0;
        end else begin
          if (state_q[ch] == ST_OFF) begin
            prebDone_q[ch] <= 1'b0;
          end else if (preb) begin
            prebDone_q[ch] <= 1'b1;
          end
          if (state_q[ch] != ST_OVLATCH) begin
            lsOv_q[ch] <= 1'b1;
          end else if (ov) begin
            lsOv_q[ch] <= 1'b1;
          end else if (uv) begin
            lsOv_q[ch] <= 1'b0;
          end
        end
      end

      // Gate commands
      always_comb begin
        hsNext = 1'b0;
        lsNext = 1'b0;
        case (state_q[ch])
          ST_RAMP, ST_READY: begin
            if (ov) begin
              hsNext = 1'b0;
              lsNext = 1'b1;
            end else begin
              hsNext = pulse_q[ch];
              if (!prebDone_q[ch]) begin
                lsNext = 1'b0;
              end else if (forced_complementary_switching) begin
                lsNext = !pulse_q[ch];
              end else begin
                lsNext = !pulse_q[ch] && !light;
              end
            end
          end
          ST_DELAY: begin
            hsNext = 1'b0;
            lsNext = ov;
          end
          ST_OVLATCH: begin
            hsNext = 1'b0;
            lsNext = lsOv_q[ch];
          end
          ST_OFF, ST_LATCHED: begin
            hsNext = 1'b0;
            lsNext = 1'b0;
          end
          default: begin
            hsNext = 1'b0;
            lsNext = 1'b0;
          end
        endcase
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          highGate[ch]        <= 1'b0;
          lowGate[ch]         <= 1'b0;
          dischargeSwitch[ch] <= 1'b1;
          softStartRef[ch*8 +: 8] <= '0;
        end else begin
          highGate[ch] <= hsNext && !thermal && !lockRst;
          lowGate[ch]  <= lsNext && !thermal && !lockRst;
          dischargeSwitch[ch] <= !en || uvLatch_q[ch] || ocLatch_q[ch] || thermal;
          softStartRef[ch*8 +: 8] <= level_q[ch];
        end
      end

      // Feedback window counted in switching ticks
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          winCnt_q[ch] <= '0;
        end else if (!win || state_q[ch] == ST_OFF) begin
          winCnt_q[ch] <= '0;
        end else if (tick && winCnt_q[ch] != 8'(PGW_TICKS)) begin
          winCnt_q[ch] <= winCnt_q[ch] + 1'b1;
        end
      end

      assign chReady[ch]   = state_q[ch] == ST_READY;
      assign chWinOk[ch]   = win && winCnt_q[ch] == 8'(PGW_TICKS);
      assign ovLatched[ch] = ovLatch_q[ch];
    end
  endgenerate

  // Power-good delay after both channels ready
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pgCnt_q <= '0;
    end else if (!(&chReady)) begin
      pgCnt_q <= '0;
    end else if (!pgDelayDone) begin
      pgCnt_q <= pgCnt_q + 1'b1;
    end
  end
  assign pgDelayDone = pgCnt_q == CNT_W'(PG_CYCLES);

  // Open-drain power-good: enable pulls the pin low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      powerGoodOut   <= 1'b0;
      powerGoodOutOe <= 1'b1;
    end else begin
      powerGoodOut   <= 1'b0;
      powerGoodOutOe <= !(pgDelayDone && (&chWinOk) && !(|ovLatched));
    end
  end

  // Linear regulators and switchover
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fiveVoltBypass          <= 1'b0;
      fiveVoltRegulatorEnable <= 1'b0;
      auxRegulatorEnable      <= 1'b0;
      auxRegulatorSelect12v   <= 1'b0;
    end else begin
      fiveVoltBypass <= inF_q[G_V2HI] ||
                        (state_q[1] != ST_OFF && inF_q[G_BYPREQ]);
      fiveVoltRegulatorEnable <= inF_q[G_LDOEN] && !inF_q[G_V2HI] &&
                                 !(state_q[1] != ST_OFF && inF_q[G_BYPREQ]);
      auxRegulatorEnable <= !inF_q[G_BIASLO] &&
                            (inF_q[G_AUXHI] || inF_q[G_AUXMID]);
      auxRegulatorSelect12v <= inF_q[G_AUXHI];
    end
  end

  // AHB-Lite slave, zero wait states
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      hrdata    <= '0;
      wrPend_q  <= 1'b0;
      wrAddr_q  <= '0;
      ctrl_q    <= CTRL_RESET;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPend_q  <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2 &&
                   haddr[31:8] == '0;
      wrAddr_q  <= haddr[7:0];
      if (wrPend_q && wrAddr_q == REG_CTRL) begin
        ctrl_q <= hwdata[1:0];
      end
      if (hsel && hready && htrans[1] && !hwrite && haddr[31:8] == '0) begin
        case (haddr[7:0])
          REG_CTRL:   hrdata <= {30'h0, ctrl_q};
          REG_STATUS: hrdata <= {9'h0, auxRegulatorSelect12v, auxRegulatorEnable,
                                 fiveVoltBypass, fiveVoltRegulatorEnable,
                                 inF_q[G_FSEL +: 2], !powerGoodOutOe,
                                 2'h0, state_q[1], 2'h0, state_q[0]};
          REG_FAULT:  hrdata <= {14'h0, lockRst, thermal, 5'h0, ocLatch_q[1],
                                 uvLatch_q[1], ovLatch_q[1], 5'h0, ocLatch_q[0],
                                 uvLatch_q[0], ovLatch_q[0]};
          default:    hrdata <= '0;
        endcase
      end
    end
  end
endmodule : dbs_sequencer

// ===== test/dbs_stage_model.sv
// Power stage and comparators answering the gate commands
module dbs_stage_model (
  input  wire logic       core_clk,
  input  wire logic [1:0] highGate,
  output logic      [1:0] pwmCompareFlag,
  output logic      [1:0] feedbackInWindow,
  output logic      [1:0] rampAboveFeedback,
  output logic      [1:0] lightLoadFlag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] onQ = 2'h0;
  initial feedbackInWindow = 2'h0;
  assign {rampAboveFeedback, lightLoadFlag} = 4'hc;
  assign pwmCompareFlag = onQ & highGate;
  always @(posedge core_clk) begin
    onQ <= highGate;
    feedbackInWindow <= feedbackInWindow | highGate;
  end
endmodule : dbs_stage_model

// ===== test/dbs_sequencer_sva.sv
// Assertions on gate, power-good and regulator pins
module dbs_sequencer_sva (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [1:0] channelEnable,
  input wire logic [1:0] overvoltageFlag,
  input wire logic       thermalShutdownFlag,
  input wire logic       channel2Above475,
  input wire logic       biasSupplyLockout,
  input wire logic       auxRegulatorSelectHigh,
  input wire logic       auxRegulatorSelectMid,
  input wire logic [1:0] highGate,
  input wire logic [1:0] lowGate,
  input wire logic [1:0] dischargeSwitch,
  input wire logic       powerGoodOutOe,
  input wire logic       fiveVoltRegulatorEnable,
  input wire logic       fiveVoltBypass,
  input wire logic       auxRegulatorEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  no_shoot_a: assert property (
    (highGate & lowGate) == 2'b00) else $error("gates overlap");
  off_discharge_a: assert property (
    (!channelEnable[0]) [*8] |-> dischargeSwitch[0]) else $error("no discharge");
  ov_high_off_a: assert property (
    overvoltageFlag[1] [*8] |-> !highGate[1]) else $error("high gate on");
  thermal_stop_a: assert property (
    thermalShutdownFlag [*8] |-> (highGate | lowGate) == 2'b00) else $error("gates on");
  pg_hold_a: assert property (
    (!channelEnable[1]) [*8] |-> powerGoodOutOe) else $error("pg high");
  bypass_swap_a: assert property (
    channel2Above475 [*8] |-> fiveVoltBypass && !fiveVoltRegulatorEnable) else $error("no bypass");
  aux_bias_a: assert property (
    biasSupplyLockout [*8] |-> !auxRegulatorEnable) else $error("aux on");
  aux_off_a: assert property (
    (!auxRegulatorSelectHigh && !auxRegulatorSelectMid) [*8] |-> !auxRegulatorEnable)
    else $error("aux not off");
  cover property ($fell(powerGoodOutOe));
  cover property (overvoltageFlag[1] [*8]);
  cover property (thermalShutdownFlag [*8]);
endmodule : dbs_sequencer_sva

bind dbs_sequencer dbs_sequencer_sva dbs_sequencer_sva_i (.*);

// ===== test/tb_top.sv
// Self-checking bench for the sequencing and fault controller
module tb_top
  import dbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ST = {24'h0, REG_STATUS}, FL = {24'h0, REG_FAULT};
  logic        core_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, powerGoodOut;
  logic        powerGoodOutOe, fiveVoltRegulatorEnable, fiveVoltBypass, auxRegulatorEnable;
  logic        auxRegulatorSelect12v, inputSupplyLockout, biasSupplyLockout, thermalShutdownFlag;
  logic        channel2Above475, fiveVoltRegulatorBypassIn, transientFlag, lightLoadModeHigh;
  logic        lightLoadModeLow, auxRegulatorSelectHigh, auxRegulatorSelectMid;
  logic        fiveVoltRegulatorEnablePin;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] softStartRef;
  logic [2:0]  hsize;
  logic [1:0]  htrans, channelEnable, overvoltageFlag, undervoltageFlag, overcurrentFlag;
  logic [1:0]  shortCircuitFlag, pwmCompareFlag, lightLoadFlag, rampAboveFeedback;
  logic [1:0]  feedbackInWindow, frequencySelectCode, highGate, lowGate, dischargeSwitch;
  int          n_mismatch, checks_done, cycles, n;
  assign hready = hreadyout;
  dbs_sequencer #(.START_CYCLES(20), .RAMP_CYCLES(512), .PG_CYCLES(30), .UV_CYCLES(40),
    .BLANK_CYCLES(100)) dbs_sequencer_i (.*);
  dbs_stage_model dbs_stage_model_i (.*);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 50000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask : cyc
  task automatic bus(input logic w, input logic [31:0] a, d, m, e);
    cyc(1);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    do cyc(1); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do cyc(1); while (hready !== 1'b1);
    if (!w) chk($sformatf("reg %h", a), e, hrdata & m);
  endtask : bus
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, channelEnable, overvoltageFlag, undervoltageFlag,
     overcurrentFlag, shortCircuitFlag, inputSupplyLockout, biasSupplyLockout,
     thermalShutdownFlag, channel2Above475, fiveVoltRegulatorBypassIn, transientFlag,
     lightLoadModeHigh, lightLoadModeLow, auxRegulatorSelectHigh, auxRegulatorSelectMid} = '0;
    {rst_n, hsize, frequencySelectCode, fiveVoltRegulatorEnablePin} = {4'h2, FSEL_HIGH, 1'b1};
    cyc(6);
    rst_n <= 1'b1;
    cyc(2);
    bus(1'b0, 32'h0, 32'h0, 32'h3, {30'h0, CTRL_RESET});
    bus(1'b1, 32'h0, 32'h1, 32'h0, 32'h0);
    bus(1'b0, 32'h0, 32'h0, 32'h3, 32'h1);
    bus(1'b1, 32'h0, 32'h3, 32'h0, 32'h0);
    bus(1'b0, 32'h10, 32'h0, '1, 32'h0);
    $display("register test done");
    for (int i = 0; i < 3; i++) begin
      {auxRegulatorSelectHigh, auxRegulatorSelectMid} <= 2'(i);
      cyc(8);
      bus(1'b0, ST, 32'h0, 32'h0060_0000, {9'h0, i == 2, i != 0, 21'h0});
    end
    biasSupplyLockout <= 1'b1;
    cyc(8);
    bus(1'b0, ST, 32'h0, 32'h0020_0000, 32'h0);
    {biasSupplyLockout, channel2Above475} <= 2'b01;
    cyc(8);
    bus(1'b0, ST, 32'h0, 32'h0018_0000, 32'h0010_0000);
    {channel2Above475, fiveVoltRegulatorBypassIn} <= 2'b01;
    cyc(8);
    bus(1'b0, ST, 32'h0, 32'h0010_0000, 32'h0);
    $display("regulator test done");
    channelEnable <= 2'b11;
    for (n = 0; powerGoodOutOe !== 1'b0 && n < 40000; n++) cyc(1);
    chk("pg delay", 32'h1, {31'h0, n > 562 && powerGoodOutOe === 1'b0});
    chk("ramp pg pin", 32'hffff, {15'h0, powerGoodOut, softStartRef});
    bus(1'b0, ST, 32'h0, 32'h0017_3f3f, 32'h0015_0808);
    overvoltageFlag <= 2'b10;
    cyc(8);
    chk("ov gates", 32'h1, {30'h0, highGate[1], lowGate[1]});
    cyc(250);
    chk("pg drop", 32'h1, {31'h0, powerGoodOutOe});
    bus(1'b0, FL, 32'h0, 32'h0000_0107, 32'h0000_0100);
    {overvoltageFlag, undervoltageFlag} <= 4'h2;
    cyc(8);
    chk("ov low gate", 32'h0, {31'h0, lowGate[1]});
    {undervoltageFlag, channelEnable} <= 4'h1;
    cyc(8);
    chk("discharge", 32'h2, {30'h0, dischargeSwitch});
    channelEnable <= 2'b11;
    cyc(8);
    bus(1'b0, FL, 32'h0, 32'h0000_0100, 32'h0);
    shortCircuitFlag <= 2'b01;
    cyc(8);
    chk("short pins", 32'h1, {29'h0, highGate[0], lowGate[0], dischargeSwitch[0]});
    bus(1'b0, FL, 32'h0, 32'h0000_0704, 32'h0000_0004);
    {shortCircuitFlag, thermalShutdownFlag} <= 3'h1;
    cyc(8);
    bus(1'b0, FL, 32'h0, 32'h0001_0000, 32'h0001_0000);
    {thermalShutdownFlag, inputSupplyLockout} <= 2'b01;
    cyc(8);
    bus(1'b0, FL, 32'h0, 32'h0002_0004, 32'h0002_0000);
    {inputSupplyLockout, undervoltageFlag} <= 3'h1;
    cyc(60);
    bus(1'b0, FL, 32'h0, 32'h0002_0002, 32'h0);
    cyc(130);
    bus(1'b0, FL, 32'h0, 32'h0000_0202, 32'h0000_0002);
    overcurrentFlag <= 2'b10;
    cyc(1000);
    bus(1'b0, FL, 32'h0, 32'h0000_0400, 32'h0);
    cyc(3000);
    bus(1'b0, FL, 32'h0, 32'h0000_0400, 32'h0000_0400);
    $display("fault test done");
    print_verdict();
  end
endmodule : tb_top
